//--- core/bus_master_pkg.sv
// Shared constants for the bus master controller.
package bus_master_pkg;

  // ----------------------------------------------------------------
  // Mode codes on the two control lines
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_READ       = 2'h0;
  localparam logic [1:0] MODE_READ_PAUSE = 2'h1;
  localparam logic [1:0] MODE_WRITE      = 2'h2;
  localparam logic [1:0] MODE_WRITE_BYTE = 2'h3;
  localparam int         MODE_WRITE_BIT  = 1;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 18;
  localparam int          DATA_W      = 16;
  localparam int          TIMER_W     = 4;
  localparam logic [17:0] ADDR_RESET  = 18'h00000;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [1:0]  MODE_RESET  = 2'h0;

  // ----------------------------------------------------------------
  // Timing: address and control setup before the master sync
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int SETUP_NS      = 75;
  localparam int SETUP_CYCLES  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SETUP_LOAD = 4'(SETUP_CYCLES);

endpackage

//--- core/setup_timer_if.sv
// Handshake between the controller and its setup timer.
`timescale 1ns/10ps
interface setup_timer_if;
  logic start;
  logic busy;
  modport ctrl  (output start, input busy);
  modport timer (input start, output busy);
endinterface

//--- core/setup_timer.sv
// Counts the address and control setup time before the master sync.
`timescale 1ns/10ps
module setup_timer
  import bus_master_pkg::*;
(
  input wire logic         clk,
  input wire logic         reset_n,
  setup_timer_if.timer     tmr
);

  typedef struct packed {
    logic [TIMER_W-1:0] count;
  } timer_state_t;

  timer_state_t st_reg;
  timer_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (tmr.start) begin
      st_next.count = SETUP_LOAD;
    end else if (st_reg.count != 4'h0) begin
      st_next.count = st_reg.count - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tmr.busy = tmr.start || (st_reg.count != 4'h0);

endmodule

//--- core/bus_master_ctrl.sv
// Bus master that runs sync-handshake cycles against a core memory bank.
//
// Overview of operation
// - After read-pause, next access writes same word.
// - Address and control stable 75 ns before sync.
// - Master sync only after slave sync released.
// - Master releases sync on slave sync.
`timescale 1ns/10ps
module bus_master_ctrl
  import bus_master_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              req_valid,
  output      logic              req_ready,
  input  wire logic [1:0]        req_mode,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output      logic              req_done,
  output      logic              req_refused,
  output      logic [DATA_W-1:0] rsp_rdata,
  output      logic              pause_pending,
  output      logic [ADDR_W-1:0] bus_addr,
  output      logic [1:0]        bus_mode,
  output      logic [DATA_W-1:0] bus_data_out,
  output      logic              bus_data_oe,
  input  wire logic [DATA_W-1:0] bus_data_in,
  output      logic              bus_msyn,
  input  wire logic              bus_ssyn
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h1,
    ST_SETUP     = 4'h2,
    ST_WAIT_SSYN = 4'h4,
    ST_WAIT_FREE = 4'h8
  } phase_t;

  typedef struct packed {
    phase_t              phase;
    logic [ADDR_W-1:0]   addr;
    logic [1:0]          mode;
    logic [DATA_W-1:0]   wdata;
    logic                data_oe;
    logic                msyn;
    logic [DATA_W-1:0]   rdata;
    logic                pause;
    logic [ADDR_W-1:0]   pause_addr;
    logic                done;
    logic                refused;
  } ctrl_state_t;

  ctrl_state_t st_reg;
  ctrl_state_t st_next;

  logic        take_req;
  logic        pair_ok;
  logic        setup_over;
  logic        bus_released;
  logic        slave_answered;
  logic        read_cycle;

  // ----------------------------------------------------------------
  // Setup timer
  // ----------------------------------------------------------------
  setup_timer_if tmr_if ();

  setup_timer u_setup_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .tmr     (tmr_if.timer)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_write(input logic [1:0] mode);
    is_write = mode[MODE_WRITE_BIT];
  endfunction

  function automatic logic same_word(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] b);
    same_word = (a[ADDR_W-1:1] == b[ADDR_W-1:1]);
  endfunction

  // A pending read-pause leaves the location cleared, so only a write
  // to that same word may follow; anything else would destroy data.
  function automatic logic pause_allows(input logic              pending,
                                        input logic [ADDR_W-1:0] paddr,
                                        input logic [1:0]        mode,
                                        input logic [ADDR_W-1:0] addr);
    pause_allows = !pending ||
                   (is_write(mode) && same_word(paddr, addr));
  endfunction

  // ----------------------------------------------------------------
  // Cycle conditions
  // ----------------------------------------------------------------
  // A refused request changes nothing, so a read-pause keeps its claim
  // on the bank until the paired write arrives.
  assign take_req       = req_valid && (st_reg.phase == ST_IDLE);
  assign pair_ok        = pause_allows(st_reg.pause, st_reg.pause_addr, req_mode, req_addr);
  assign setup_over     = !tmr_if.busy;
  assign bus_released   = !bus_ssyn;
  assign slave_answered = bus_ssyn;
  assign read_cycle     = !is_write(st_reg.mode);

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.done    = 1'b0;
    st_next.refused = 1'b0;
    tmr_if.start    = 1'b0;
    case (st_reg.phase)
      ST_IDLE: begin
        if (take_req) begin
          if (pair_ok) begin
            st_next.addr    = req_addr;
            st_next.mode    = req_mode;
            st_next.wdata   = req_wdata;
            st_next.data_oe = is_write(req_mode);
            st_next.phase   = ST_SETUP;
            tmr_if.start    = 1'b1;
          end else begin
            st_next.refused = 1'b1;
          end
        end
      end

      ST_SETUP: begin
        // Waiting on a slave that still answers keeps two sync
        // handshakes from overlapping on the shared lines.
        if (setup_over && bus_released) begin
          st_next.msyn  = 1'b1;
          st_next.phase = ST_WAIT_SSYN;
        end
      end

      ST_WAIT_SSYN: begin
        if (slave_answered) begin
          st_next.msyn = 1'b0;
          if (read_cycle) begin
            st_next.rdata = bus_data_in;
          end
          st_next.pause      = (st_reg.mode == MODE_READ_PAUSE);
          st_next.pause_addr = st_reg.addr;
          st_next.phase      = ST_WAIT_FREE;
        end
      end

      ST_WAIT_FREE: begin
        // Write data is held until the slave lets go, so it never sees
        // the lines change under a cycle it is still finishing.
        if (bus_released) begin
          st_next.data_oe = 1'b0;
          st_next.done    = 1'b1;
          st_next.phase   = ST_IDLE;
        end
      end

      default: begin
        st_next.phase = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.phase      <= ST_IDLE;
      st_reg.addr       <= ADDR_RESET;
      st_reg.mode       <= MODE_RESET;
      st_reg.wdata      <= DATA_RESET;
      st_reg.data_oe    <= 1'b0;
      st_reg.msyn       <= 1'b0;
      st_reg.rdata      <= DATA_RESET;
      st_reg.pause      <= 1'b0;
      st_reg.pause_addr <= ADDR_RESET;
      st_reg.done       <= 1'b0;
      st_reg.refused    <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign req_ready     = (st_reg.phase == ST_IDLE);
  assign req_done      = st_reg.done;
  assign req_refused   = st_reg.refused;
  assign rsp_rdata     = st_reg.rdata;
  assign pause_pending = st_reg.pause;
  assign bus_addr      = st_reg.addr;
  assign bus_mode      = st_reg.mode;
  assign bus_data_out  = st_reg.wdata;
  assign bus_data_oe   = st_reg.data_oe;
  assign bus_msyn      = st_reg.msyn;

endmodule

//--- tb/bus_master_ctrl_asserts.sv
// Handshake and pairing checks on the bus side of the master controller.
`timescale 1ns/10ps
module bus_master_ctrl_asserts
  import bus_master_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [1:0]        bus_mode,
  input wire logic              bus_data_oe,
  input wire logic              bus_msyn,
  input wire logic              bus_ssyn
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Own record of an open read-pause, kept apart from the design's flag so a stuck flag shows.
  logic              pause_reg;
  logic [ADDR_W-1:0] pause_addr_reg;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pause_reg      <= 1'b0;
      pause_addr_reg <= ADDR_RESET;
    end else if (bus_msyn) begin
      pause_reg      <= bus_mode == MODE_READ_PAUSE;
      pause_addr_reg <= bus_addr;
    end
  end
  property p_setup;
    $rose(bus_msyn) |-> bus_addr == $past(bus_addr, 2) && bus_mode == $past(bus_mode, 2);
  endproperty
  a_setup: assert property (p_setup) else $error("lines moved in setup");
  property p_wait;
    $rose(bus_msyn) |-> !$past(bus_ssyn);
  endproperty
  a_wait: assert property (p_wait) else $error("sync over busy bus");
  property p_release;
    bus_msyn && bus_ssyn |=> !bus_msyn;
  endproperty
  a_release: assert property (p_release) else $error("sync held");
  property p_drive;
    bus_msyn |-> bus_data_oe == bus_mode[MODE_WRITE_BIT];
  endproperty
  a_drive: assert property (p_drive) else $error("data drive wrong for mode");
  property p_pair;
    $rose(bus_msyn) && pause_reg |-> bus_mode[MODE_WRITE_BIT] && bus_addr[17:1] == pause_addr_reg[17:1];
  endproperty
  a_pair: assert property (p_pair) else $error("pause not closed");
  c_read: cover property ($rose(bus_msyn) && bus_mode == MODE_READ);
  c_byte: cover property ($rose(bus_msyn) && bus_mode == MODE_WRITE_BYTE);
  c_pair: cover property ($rose(bus_msyn) && pause_reg);
endmodule

//--- tb/mem_model.sv
// Behavioural core bank answering the sync handshake.
`timescale 1ns/10ps
module mem_model
  import bus_master_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [3:0]        latency,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [1:0]        bus_mode,
  input  wire logic [DATA_W-1:0] bus_data_out,
  input  wire logic              bus_data_oe,
  input  wire logic              bus_msyn,
  output      logic              bus_ssyn,
  output      logic [DATA_W-1:0] bus_data_in
);
  // Bank straps: a plain bank at base 0 keeps every test address inside it.
  localparam logic [ADDR_W-1:0] BANK_BASE   = 18'h00000;
  localparam bit                INTERLEAVED = 1'b0;
  logic [DATA_W-1:0] core [0:16383];
  logic [DATA_W-1:0] data_reg, old;
  logic [ADDR_W-1:0] addr_l;
  logic [1:0]        mode_l;
  logic [3:0]        wait_cnt;
  logic              pause;
  wire               lower_only = (BANK_BASE >= 18'h38000) || (INTERLEAVED && BANK_BASE >= 18'h30000);
  wire               in_bank = lower_only || addr_l < BANK_BASE + 18'h08000;
  wire               hit = addr_l >= BANK_BASE && in_bank && addr_l < 18'h3E000;
  wire  [3:0]        y_switch = {addr_l[14], addr_l[6], addr_l[5], addr_l[3]};
  wire  [2:0]        y_driver = {addr_l[4], addr_l[2], addr_l[1]};
  wire  [3:0]        x_switch = addr_l[13:10];
  wire  [2:0]        x_driver = addr_l[9:7];
  wire  [13:0]       word = {x_switch, x_driver, y_switch, y_driver};
  // Lines the master leaves undriven read inverted, so a missing enable corrupts the store.
  wire  [DATA_W-1:0] wdata = bus_data_oe ? bus_data_out : ~bus_data_out;
  // Outside a read answer the lines show the inverse, so a stale sample cannot pass.
  assign bus_data_in = (bus_ssyn && !mode_l[1]) ? data_reg : ~data_reg;
  assign old = pause ? data_reg : core[word];
  // The latches follow the lines until sync starts a cycle, then hold.
  always @(posedge clk) begin
    if (!bus_msyn) begin
      addr_l <= bus_addr;
      mode_l <= bus_mode;
    end
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_ssyn <= 1'b0;
      wait_cnt <= 4'h0;
      pause <= 1'b0;
    end else if (!bus_msyn) begin
      bus_ssyn <= 1'b0;
      wait_cnt <= 4'h0;
    end else if (hit && !bus_ssyn && wait_cnt < latency) begin
      wait_cnt <= wait_cnt + 4'h1;
    end else if (hit && !bus_ssyn) begin
      bus_ssyn <= 1'b1;
      pause <= mode_l == MODE_READ_PAUSE;
      if (!mode_l[1]) data_reg <= core[word];
      if (mode_l == MODE_READ_PAUSE) core[word] <= DATA_RESET;
      if (mode_l == MODE_WRITE) core[word] <= wdata;
      if (mode_l == MODE_WRITE_BYTE) core[word] <= addr_l[0] ? {wdata[15:8], old[7:0]}
                                                           : {old[15:8], wdata[7:0]};
    end
  end
endmodule

//--- tb/tb.sv
// Self-checking bench for the bus master controller.
`timescale 1ns/10ps
module tb;
  import bus_master_pkg::*;
  logic              clk = 0, reset_n = 0, req_valid = 0, r;
  logic              req_ready, req_done, req_refused, pause_pending, bus_data_oe, bus_msyn, bus_ssyn;
  logic [1:0]        req_mode = 2'h0, bus_mode;
  logic [3:0]        lat = 4'h0;
  logic [ADDR_W-1:0] req_addr = 18'h00000, bus_addr;
  logic [DATA_W-1:0] req_wdata = 16'h0000, rsp_rdata, bus_data_out, bus_data_in;
  int                miscompares = 0, comparisons = 0;
  bus_master_ctrl u_bus_master_ctrl (.clk, .reset_n, .req_valid, .req_ready, .req_mode, .req_addr, .req_wdata,
    .req_done, .req_refused, .rsp_rdata, .pause_pending, .bus_addr, .bus_mode, .bus_data_out, .bus_data_oe,
    .bus_data_in, .bus_msyn, .bus_ssyn);
  mem_model u_mem_model (.clk, .reset_n, .latency(lat), .bus_addr, .bus_mode, .bus_data_out, .bus_data_oe, .bus_msyn,
    .bus_ssyn, .bus_data_in);
  initial forever #20 clk = ~clk;
  task automatic summarize();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // A dead slave would hang the controller forever, so every wait is capped.
  task automatic access(input logic [1:0] m, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    req_mode = m;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(posedge clk);
    #1 req_valid = 1'b0;
    for (n = 0; n < 400 && req_done !== 1'b1 && req_refused !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    if (n == 400) begin
      miscompares++;
      summarize();
    end
    r = req_refused;
    check(16'(req_ready), 16'h0001);
  endtask
  task automatic rd(input logic [1:0] m, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    access(m, a, 16'h0000);
    check(rsp_rdata, exp);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int t = 0; t < 2; t++) begin
      lat = t ? 4'h9 : 4'h0;
      access(MODE_WRITE, 18'h00010, 16'hA5C3);
      rd(MODE_READ, 18'h00010, 16'hA5C3);
      rd(MODE_READ, 18'h00010, 16'hA5C3);
      access(MODE_WRITE, 18'h00020, 16'h1234);
      access(MODE_WRITE_BYTE, 18'h00021, 16'hAB00);
      access(MODE_WRITE_BYTE, 18'h00020, 16'h00CD);
      rd(MODE_READ_PAUSE, 18'h00020, 16'hABCD);
      check(16'(pause_pending), 16'h0001);
      access(MODE_READ, 18'h00010, 16'h0000);
      check(16'(r), 16'h0001);
      access(MODE_WRITE_BYTE, 18'h00021, 16'h5500);
      check(16'(pause_pending), 16'h0000);
      rd(MODE_READ, 18'h00020, 16'h55CD);
      rd(MODE_READ_PAUSE, 18'h00010, 16'hA5C3);
      access(MODE_WRITE, 18'h00010, 16'h0F0F);
      rd(MODE_READ, 18'h00010, 16'h0F0F);
      $display("test pass %0d ended", t);
    end
    summarize();
  end
endmodule
bind bus_master_ctrl bus_master_ctrl_asserts u_bus_master_ctrl_asserts (.clk, .reset_n, .bus_addr, .bus_mode,
  .bus_data_oe, .bus_msyn, .bus_ssyn);
